/* cpu_interrupt_enable_flag_logic_tb.sv */
// Bench: both ends joined by the link, driven from the command and request inputs
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module cpu_interrupt_enable_flag_logic_tb;
    logic                      MCLK = 1'b0;
    logic                      SRST = 1'b1;
    logic                      CMD_WR = 1'b0;
    logic                      CMD_RD = 1'b0;
    logic [7:0]                CMD_ADDR = 8'h00;
    logic [7:0]                CMD_WDATA = 8'h00;
    logic                      RETURN_FROM_IRQ_INSTR_EXEC = 1'b0;
    logic [12:0]               ev = 13'h0000;
    logic [9:0]                MOD_FLAG = 10'h000;
    icefl_pkg::icefl_byte_type RD_DATA;
    logic                      RD_VALID;
    logic                      VEC_TAKEN;
    icefl_pkg::icefl_vec_type  VEC_ADDR;
    icefl_pkg::icefl_srcvec_type CPU_FLAGS;
    logic [1:0]                IN_SERVICE;
    logic                      IN_CALL;
    int                        bad_count = 0;
    int                        num_checks = 0;
    always #5 MCLK = ~MCLK;
    icefl_if icefl_if_i ();
    icefl_dev icefl_dev_i (.MCLK(MCLK), .SRST(SRST), .cpu(icefl_if_i.dev), .EVT(ev[9:0]),
        .USB_EVT(ev[10]), .AUDIO_TX_EVT(ev[11]), .AUDIO_RX_EVT(ev[12]), .MOD_FLAG(MOD_FLAG),
        .CPU_FLAGS(CPU_FLAGS), .IN_SERVICE(IN_SERVICE));
    icefl_cpu icefl_cpu_i (.MCLK(MCLK), .SRST(SRST), .dev(icefl_if_i.cpu), .CMD_WR(CMD_WR),
        .CMD_RD(CMD_RD), .CMD_ADDR(CMD_ADDR), .CMD_WDATA(CMD_WDATA), .RETURN_FROM_IRQ_INSTR_EXEC(RETURN_FROM_IRQ_INSTR_EXEC),
        .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .VEC_TAKEN(VEC_TAKEN), .VEC_ADDR(VEC_ADDR), .IN_CALL(IN_CALL));
    icefl_checker icefl_checker_i (.MCLK(MCLK), .SRST(SRST), .sfr_addr(icefl_if_i.sfr_addr),
        .sfr_wdata(icefl_if_i.sfr_wdata), .sfr_rdata(icefl_if_i.sfr_rdata), .sfr_wr(icefl_if_i.sfr_wr),
        .sfr_rd(icefl_if_i.sfr_rd), .irq_req(icefl_if_i.irq_req), .irq_src(icefl_if_i.irq_src),
        .irq_vec(icefl_if_i.irq_vec), .irq_ack(icefl_if_i.irq_ack), .irq_ack_src(icefl_if_i.irq_ack_src),
        .return_from_irq_instr(icefl_if_i.return_from_irq_instr));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    // Reserved bits read one, unused bits zero, flags of sources 3..0 at bits 7,5,3,1
    function automatic icefl_pkg::icefl_byte_type flags_exp(input logic [3:0] m);
        return {m[3], 1'b0, m[2], 1'b0, m[1], 1'b1, m[0], 1'b1};
    endfunction : flags_exp
    function automatic icefl_pkg::icefl_vec_type vec_exp(input int s);
        return 16'h0003 + 16'(8 * s);
    endfunction : vec_exp
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done
    task automatic fail_wait();
        bad_count++;
        $display("[ERR] wait expected done seen timeout");
        test_done();
    endtask : fail_wait
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge MCLK);
        CMD_ADDR = a;
        CMD_WDATA = d;
        CMD_WR = 1'b1;
        @(negedge MCLK);
        CMD_WR = 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        int n;
        @(negedge MCLK);
        CMD_ADDR = a;
        CMD_RD = 1'b1;
        @(negedge MCLK);
        CMD_RD = 1'b0;
        for (n = 0; n < 8 && RD_VALID !== 1'b1; n++)
            @(negedge MCLK);
        if (RD_VALID !== 1'b1)
            fail_wait();
        `CHK($sformatf("reg %h", a), e & m, RD_DATA & m)
    endtask : rdc
    task automatic pulse(input int s);
        @(negedge MCLK);
        ev[s] = 1'b1;
        @(negedge MCLK);
        ev = 13'h0000;
    endtask : pulse
    task automatic wait_vec(input int s);
        int n;
        for (n = 0; n < 40 && VEC_TAKEN !== 1'b1; n++)
            @(negedge MCLK);
        if (VEC_TAKEN !== 1'b1)
            fail_wait();
        `CHK("vector", vec_exp(s), VEC_ADDR)
    endtask : wait_vec
    task automatic no_vec(input int n);
        int k;
        int hits;
        hits = 0;
        for (k = 0; k < n; k++)
        begin
            @(negedge MCLK);
            hits += (VEC_TAKEN === 1'b1);
        end
        `CHK("quiet", 0, hits)
    endtask : no_vec
    task automatic ret();
        @(negedge MCLK);
        RETURN_FROM_IRQ_INSTR_EXEC = 1'b1;
        @(negedge MCLK);
        RETURN_FROM_IRQ_INSTR_EXEC = 1'b0;
        repeat (2) @(negedge MCLK);
    endtask : ret
    initial
    begin
        logic [31:0] seed;
        int k;
        int n;
        int s;
        int calls;
        repeat (8) @(posedge MCLK);
        @(negedge MCLK);
        SRST = 1'b0;
        rdc(8'h88, flags_exp(4'h0), 8'hff);
        rdc(8'hb8, 8'h00, 8'hff);
        rdc(8'h55, 8'h00, 8'hff);
        seed = 32'h18;
        for (k = 0; k < 6; k++)
        begin
            seed = xs(seed);
            wr(8'hb8, seed[7:0]);
            rdc(8'hb8, seed[7:0], 8'h3f);
        end
        wr(8'hb8, 8'h00);
        // Flags set with everything disabled; audio receive shares source 3
        pulse(2);
        pulse(12);
        pulse(1);
        pulse(0);
        rdc(8'h88, flags_exp(4'hf), 8'hff);
        `CHK("cpu flags", 10'h00f, CPU_FLAGS)
        no_vec(10);
        // All four pending at one level: polled in index order, one service at a time
        wr(8'ha8, 8'h8f);
        for (k = 0; k < 4; k++)
        begin
            wait_vec(k);
            rdc(8'h88, flags_exp(4'hf << (k + 1)), 8'hff);
            no_vec(12);
            ret();
        end
        wr(8'ha8, 8'h82);
        @(negedge MCLK);
        ev[2] = 1'b1;
        calls = 0;
        for (n = 0; n < 40 && VEC_TAKEN !== 1'b1; n++)
        begin
            @(negedge MCLK);
            ev = 13'h0000;
            calls += (IN_CALL === 1'b1);
        end
        `CHK("latency", 9, n)
        `CHK("call cycles", 6, calls)
        ret();
        wr(8'ha8, 8'h02);
        pulse(2);
        no_vec(12);
        wr(8'ha8, 8'h82);
        wait_vec(2);
        ret();
        // Sources 8 and 9 raised to the high level; low service pre-empted
        wr(8'ha9, 8'h10);
        wr(8'hb8, 8'h10);
        pulse(2);
        wait_vec(2);
        pulse(8);
        wait_vec(8);
        pulse(2);
        no_vec(12);
        `CHK("service nest", 2'b11, IN_SERVICE)
        wr(8'hd9, 8'h00);
        ret();
        no_vec(12);
        `CHK("service low", 2'b01, IN_SERVICE)
        ret();
        wait_vec(2);
        ret();
        wr(8'ha9, 8'h00);
        // Second enable fields; events 10 and 11 reach sources 5 and 7 through shared bits
        for (k = 0; k < 8; k++)
        begin
            s = (k < 6) ? k + 4 : 2 * k - 7;
            wr(8'hb8, 8'h01 << (s - 4));
            pulse(k + 4);
            wait_vec(s);
            wr(8'hd9, 8'h00);
            ret();
        end
        wr(8'hb8, 8'h01);
        @(negedge MCLK);
        MOD_FLAG = 10'h050;
        @(negedge MCLK);
        MOD_FLAG = 10'h010;
        wait_vec(4);
        wr(8'hd9, 8'h00);
        MOD_FLAG = 10'h000;
        ret();
        test_done();
    end
endmodule : cpu_interrupt_enable_flag_logic_tb

/* icefl_checker.sv */
// Checker on the link: vector map, gating, acknowledge timing and enable readback
`timescale 1ns/10ps
module icefl_checker (
    // Clock and reset
    input wire logic                 MCLK,
    input wire logic                 SRST,
    // Link signals
    input icefl_pkg::icefl_byte_type sfr_addr,
    input icefl_pkg::icefl_byte_type sfr_wdata,
    input icefl_pkg::icefl_byte_type sfr_rdata,
    input wire logic                 sfr_wr,
    input wire logic                 sfr_rd,
    input wire logic                 irq_req,
    input icefl_pkg::icefl_src_type  irq_src,
    input icefl_pkg::icefl_vec_type  irq_vec,
    input wire logic                 irq_ack,
    input icefl_pkg::icefl_src_type  irq_ack_src,
    input wire logic                 return_from_irq_instr
);
    logic       ge_q;
    logic [3:0] en1_q;
    logic [5:0] en2_q;
    logic [9:0] en_vec;
    // Shadow of the enables as written over the link, in source order
    assign en_vec = {en2_q, en1_q[3], en1_q[1], en1_q[2], en1_q[0]};
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            ge_q  <= 1'b0;
            en1_q <= 4'h0;
            en2_q <= 6'h00;
        end
        else if (sfr_wr && sfr_addr == 8'ha8)
        begin
            ge_q  <= sfr_wdata[7];
            en1_q <= sfr_wdata[3:0];
        end
        else if (sfr_wr && sfr_addr == 8'hb8)
            en2_q <= sfr_wdata[5:0];
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (SRST);
    sequence s_no_ack;
        !irq_ack [*7];
    endsequence
    property p_vec_map;
        irq_req |-> irq_vec == 16'h0003 + {irq_src, 3'h0};
    endproperty
    property p_req_enabled;
        $rose(irq_req) && $stable(en_vec) && $stable(ge_q) |-> ge_q && en_vec[irq_src];
    endproperty
    property p_global;
        !ge_q && !$past(ge_q) |-> !irq_req;
    endproperty
    property p_ack_drop;
        irq_ack |=> !irq_req;
    endproperty
    property p_ack_pulse;
        irq_ack |=> !irq_ack;
    endproperty
    property p_latency;
        irq_ack |-> $past(irq_req, 7) && irq_ack_src == $past(irq_src, 7);
    endproperty
    property p_min_wait;
        $rose(irq_req) |-> s_no_ack;
    endproperty
    property p_en2_rd;
        sfr_rd && sfr_addr == 8'hb8 |=> sfr_rdata[5:0] == $past(en2_q);
    endproperty
    a_vec_map: assert property (p_vec_map)
        else $error("vector address does not match source");
    a_req_enabled: assert property (p_req_enabled)
        else $error("request raised for a disabled source");
    a_global: assert property (p_global)
        else $error("request raised with global enable off");
    a_ack_drop: assert property (p_ack_drop)
        else $error("request still high after acknowledge");
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("acknowledge longer than one cycle");
    a_latency: assert property (p_latency)
        else $error("acknowledge not seven cycles after request");
    a_min_wait: assert property (p_min_wait)
        else $error("acknowledge sooner than seven cycles");
    a_en2_rd: assert property (p_en2_rd)
        else $error("second enable readback wrong");
endmodule : icefl_checker

/* icefl_cpu.sv */
// CPU core end: register access, forced long call and return from service
`timescale 1ns/10ps
`include "icefl_regs.svh"
module icefl_cpu (
    // Clock and reset
    input  wire logic                      MCLK,
    input  wire logic                      SRST,
    // Link to the interrupt logic
    icefl_if.cpu                           dev,
    // Software register access
    input  wire logic                      CMD_WR,
    input  wire logic                      CMD_RD,
    input  wire logic [7:0]                CMD_ADDR,
    input  wire logic [7:0]                CMD_WDATA,
    input  wire logic                      RETURN_FROM_IRQ_INSTR_EXEC,
    output icefl_pkg::icefl_byte_type      RD_DATA,
    output logic                           RD_VALID,
    // Vectoring status
    output logic                           VEC_TAKEN,
    output icefl_pkg::icefl_vec_type       VEC_ADDR,
    output logic                           IN_CALL
);
    icefl_pkg::icefl_state_type state_q;
    icefl_pkg::icefl_state_type state_d;
    icefl_pkg::icefl_cnt_type   cnt_q;
    icefl_pkg::icefl_src_type   src_q;
    icefl_pkg::icefl_vec_type   vec_q;
    logic                       rd_pend_q;

    // The request is ignored in the ack cycle: it still shows the source just taken
    wire start     = (state_q == icefl_pkg::ICEFL_IDLE) & dev.irq_req & ~dev.irq_ack;
    wire call_done = (state_q == icefl_pkg::ICEFL_CALL) & (cnt_q == 3'(`ICEFL_CALL_CYC - 1));

    always_comb
    begin
        case (state_q)
            icefl_pkg::ICEFL_IDLE: state_d = start ? icefl_pkg::ICEFL_CALL : icefl_pkg::ICEFL_IDLE;
            icefl_pkg::ICEFL_CALL: state_d = call_done ? icefl_pkg::ICEFL_IDLE : icefl_pkg::ICEFL_CALL;
            default:               state_d = icefl_pkg::ICEFL_IDLE;
        endcase
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            state_q         <= icefl_pkg::ICEFL_IDLE;
            cnt_q           <= 3'h0;
            src_q           <= 4'h0;
            vec_q           <= 16'h0000;
            dev.irq_ack     <= 1'b0;
            dev.irq_ack_src <= 4'h0;
            VEC_TAKEN       <= 1'b0;
            VEC_ADDR        <= 16'h0000;
            IN_CALL         <= 1'b0;
        end
        else
        begin
            state_q         <= state_d;
            cnt_q           <= start ? 3'h0 : (state_q == icefl_pkg::ICEFL_CALL ? cnt_q + 3'h1 : cnt_q);
            src_q           <= start ? dev.irq_src : src_q;
            vec_q           <= start ? dev.irq_vec : vec_q;
            dev.irq_ack     <= call_done;                     // RL8
            dev.irq_ack_src <= src_q;
            VEC_TAKEN       <= call_done;
            VEC_ADDR        <= call_done ? vec_q : VEC_ADDR;
            IN_CALL         <= (state_d == icefl_pkg::ICEFL_CALL);
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            dev.sfr_wr    <= 1'b0;
            dev.sfr_rd    <= 1'b0;
            dev.sfr_addr  <= 8'h00;
            dev.sfr_wdata <= 8'h00;
            dev.return_from_irq_instr      <= 1'b0;
            rd_pend_q     <= 1'b0;
            RD_VALID      <= 1'b0;
            RD_DATA       <= 8'h00;
        end
        else
        begin
            dev.sfr_wr    <= CMD_WR;
            dev.sfr_rd    <= CMD_RD & ~CMD_WR;
            dev.sfr_addr  <= CMD_ADDR;
            dev.sfr_wdata <= CMD_WDATA;
            dev.return_from_irq_instr      <= RETURN_FROM_IRQ_INSTR_EXEC;                       // RL6
            rd_pend_q     <= dev.sfr_rd;
            RD_VALID      <= rd_pend_q;
            RD_DATA       <= rd_pend_q ? dev.sfr_rdata : RD_DATA;
        end
    end
endmodule : icefl_cpu

/* icefl_dev.sv */
// Interrupt enable and flag logic: enables, first CPU flag register, selection and service tracking
`timescale 1ns/10ps
`include "icefl_regs.svh"
// Function
// (RL1) Second enable resets zero; bit per source
// (RL2) Bit 1 enables port two and USB
// (RL3) Bit 3 shared by serial1 and audio transmit
// (RL4) Enabled request vectors to its fixed address
// (RL5) Active service pre-empted only by higher priority
// (RL6) Return instruction ends the service
// (RL7) Request sets flag regardless of enable
// (RL8) Enabled flag acknowledged by forced long call
// (RL9) Lower or equal request waits while serviced
// (RL10) Least latency: one detect, six call cycles
// (RL11) Software clears CPU flag before module flag
// (RL12) Port requests removed by clearing module flag
// (RL13) Four flags here hardware-cleared on vectoring
// (RL14) Module flag clear re-raises remaining enabled flags
// (RL15) Bit 7 serial1/audio receive, cleared on vectoring
// (RL16) Bit 5 converter request, cleared on vectoring
// (RL17) Bit 3 serial0 receive, cleared on vectoring
// (RL18) Bit 1 radio done, cleared on vectoring
// (RL19) Bits 2,0 reset one; 6,4 zero
// (RL20) Software best clears one module flag per entry
// (RL21) Global enable bit 7 gates every acknowledgement; here it gates only the request, so a call already begun is still acknowledged
// (RL22) Same-priority ties resolved by fixed polling order
module icefl_dev (
    // Clock and reset
    input  wire logic                      MCLK,
    input  wire logic                      SRST,
    // Link to the CPU core
    icefl_if.dev                           cpu,
    // Peripheral request pulses: one per source, plus USB and audio events on shared sources
    input  wire logic [9:0]                EVT,
    input  wire logic                      USB_EVT,
    input  wire logic                      AUDIO_TX_EVT,
    input  wire logic                      AUDIO_RX_EVT,
    // Module flag levels, one per source
    input  wire logic [9:0]                MOD_FLAG,
    // Status
    output icefl_pkg::icefl_srcvec_type    CPU_FLAGS,
    output logic [1:0]                     IN_SERVICE
);
    icefl_pkg::icefl_byte_type    flags_first_q;
    icefl_pkg::icefl_byte_type    flags_first_d;
    logic [5:0]                   aux_q;
    logic [5:0]                   aux_d;
    icefl_pkg::icefl_byte_type    en_first_q;
    icefl_pkg::icefl_byte_type    en_second_q;
    icefl_pkg::icefl_byte_type    en_third_q;
    icefl_pkg::icefl_byte_type    prio_q;
    icefl_pkg::icefl_srcvec_type  mod_prev_q;
    logic                         act_hi_q;
    logic                         act_lo_q;
    logic                         req_hi_q;
    icefl_pkg::icefl_byte_type    rd_mux;

    // Address decode, shared by the write strobes and the read mux
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
        reg_hit = (addr == offset);
    endfunction : reg_hit

    // Lowest index wins among the set bits
    function automatic icefl_pkg::icefl_src_type first_set(input icefl_pkg::icefl_srcvec_type v);
        first_set = 4'h0;
        for (int i = `ICEFL_NSRC - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                first_set = 4'(i);
            end
        end
    endfunction : first_set

    wire hit_flags = reg_hit(cpu.sfr_addr, `ICEFL_FLAGS_FIRST_ADDR);
    wire hit_en1   = reg_hit(cpu.sfr_addr, `ICEFL_EN_FIRST_ADDR);
    wire hit_en2   = reg_hit(cpu.sfr_addr, `ICEFL_EN_SECOND_ADDR);
    wire hit_en3   = reg_hit(cpu.sfr_addr, `ICEFL_EN_THIRD_ADDR);
    wire hit_prio  = reg_hit(cpu.sfr_addr, `ICEFL_PRIO_ADDR);
    wire hit_aux   = reg_hit(cpu.sfr_addr, `ICEFL_FLAGS_AUX_ADDR);

    wire wr_flags  = cpu.sfr_wr & hit_flags;
    wire wr_aux    = cpu.sfr_wr & hit_aux;

    // Shared enables: one request line per enable bit
    wire [9:0] evt_v = EVT | {2'b00, AUDIO_TX_EVT, 1'b0, USB_EVT, 1'b0, AUDIO_RX_EVT, 3'b000}; // RL2 RL3

    // Per-source enables in source order
    wire [9:0] en_v = {en_second_q[`ICEFL_WATCHDOG_EN_BIT],
                       en_second_q[`ICEFL_PORT_ONE_EN_BIT],
                       en_second_q[`ICEFL_SERIAL1_TX_EN_BIT],
                       en_second_q[`ICEFL_SERIAL0_TX_EN_BIT],
                       en_second_q[`ICEFL_PORT_TWO_EN_BIT],
                       en_second_q[`ICEFL_RADIO_GEN_EN_BIT],
                       en_first_q[`ICEFL_SERIAL1_RX_EN_BIT],
                       en_first_q[`ICEFL_CONVERTER_EN_BIT],
                       en_first_q[`ICEFL_SERIAL0_RX_EN_BIT],
                       en_first_q[`ICEFL_RADIO_DONE_EN_BIT]};                 // RL1

    // A falling module flag re-checks every module flag still enabled and set
    wire       mod_cleared = |(mod_prev_q & ~MOD_FLAG);                       // RL14
    wire [9:0] reraise_v   = mod_cleared ? (MOD_FLAG & en_v) : 10'h000;       // RL14 RL12
    wire [9:0] set_v       = evt_v | reraise_v;                               // RL7

    wire [9:0] ack_v = cpu.irq_ack ? 10'(10'h001 << cpu.irq_ack_src) : 10'h000;

    wire [9:0] flags_v = {aux_q, flags_first_q[7], flags_first_q[5], flags_first_q[3], flags_first_q[1]};

    // Priority: one bit per pair of sources
    wire [9:0] prio_v;
    genvar g;
    generate
        for (g = 0; g < `ICEFL_NSRC; g++)
        begin : g_prio
            assign prio_v[g] = prio_q[g / 2];
        end
    endgenerate

    wire [9:0] pend_v  = flags_v & en_v & {10{en_first_q[`ICEFL_GLOBAL_EN_BIT]}}; // RL21 RL4
    wire [9:0] hi_pend = pend_v & prio_v;
    wire [9:0] lo_pend = pend_v & ~prio_v;
    wire       any_hi  = |hi_pend;
    wire       any_lo  = |lo_pend;

    // A high request may pre-empt a low service; nothing pre-empts a high one
    wire take_hi = any_hi & ~act_hi_q;                                        // RL5 RL9
    wire take_lo = any_lo & ~act_hi_q & ~act_lo_q;                            // RL9
    wire req_d   = (take_hi | take_lo) & ~cpu.irq_ack;

    wire icefl_pkg::icefl_src_type src_d = any_hi ? first_set(hi_pend) : first_set(lo_pend); // RL22
    wire icefl_pkg::icefl_vec_type vec_d = 16'(`ICEFL_VEC_BASE + 16'(src_d) * `ICEFL_VEC_STEP); // RL4

    wire ack_hi = cpu.irq_ack & prio_v[cpu.irq_ack_src];

    // Writes land first, hardware clear next, a set always wins
    always_comb
    begin
        flags_first_d = wr_flags ? cpu.sfr_wdata : flags_first_q;
        for (int i = 0; i < `ICEFL_NHWCLR; i++)
        begin
            if (ack_v[i])
            begin
                flags_first_d[2 * i + 1] = 1'b0;                              // RL13 RL15 RL16 RL17 RL18
            end
            if (set_v[i])
            begin
                flags_first_d[2 * i + 1] = 1'b1;                              // RL7
            end
        end
    end

    // Flags of the remaining sources are cleared by software only
    assign aux_d = (wr_aux ? cpu.sfr_wdata[5:0] : aux_q) | set_v[9:4];        // RL7 RL11

    always_comb
    begin
        rd_mux = 8'h00;
        if (hit_flags)
        begin
            rd_mux = flags_first_q;
        end
        else if (hit_en1)
        begin
            rd_mux = en_first_q;
        end
        else if (hit_en2)
        begin
            rd_mux = en_second_q;
        end
        else if (hit_en3)
        begin
            rd_mux = en_third_q;
        end
        else if (hit_prio)
        begin
            rd_mux = {3'b000, prio_q[4:0]};
        end
        else if (hit_aux)
        begin
            rd_mux = {2'b00, aux_q};
        end
    end

    // Register file
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            flags_first_q <= `ICEFL_FLAGS_FIRST_RST;                          // RL19
            aux_q         <= `ICEFL_AUX_RST;
            en_first_q    <= `ICEFL_EN_RST;
            en_second_q   <= `ICEFL_EN_RST;                                   // RL1
            en_third_q    <= `ICEFL_EN_RST;
            prio_q        <= `ICEFL_PRIO_RST;
            cpu.sfr_rdata <= 8'h00;
        end
        else
        begin
            flags_first_q <= flags_first_d;
            aux_q         <= aux_d;
            en_first_q    <= (cpu.sfr_wr & hit_en1) ? cpu.sfr_wdata : en_first_q;
            en_second_q   <= (cpu.sfr_wr & hit_en2) ? cpu.sfr_wdata : en_second_q; // RL1
            en_third_q    <= (cpu.sfr_wr & hit_en3) ? cpu.sfr_wdata : en_third_q;
            prio_q        <= (cpu.sfr_wr & hit_prio) ? {3'b000, cpu.sfr_wdata[4:0]} : prio_q;
            cpu.sfr_rdata <= cpu.sfr_rd ? rd_mux : cpu.sfr_rdata;
        end
    end

    // Request detection and service tracking
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            mod_prev_q  <= 10'h000;
            cpu.irq_req <= 1'b0;
            cpu.irq_src <= 4'h0;
            cpu.irq_vec <= 16'h0000;
            req_hi_q    <= 1'b0;
            act_hi_q    <= 1'b0;
            act_lo_q    <= 1'b0;
            CPU_FLAGS   <= 10'h000;
            IN_SERVICE  <= 2'b00;
        end
        else
        begin
            mod_prev_q  <= MOD_FLAG;
            cpu.irq_req <= req_d;                                             // RL8 RL10
            cpu.irq_src <= src_d;
            cpu.irq_vec <= vec_d;                                             // RL4
            req_hi_q    <= any_hi;
            act_hi_q    <= (act_hi_q & ~cpu.return_from_irq_instr) | ack_hi;                   // RL5 RL6
            act_lo_q    <= (act_lo_q & ~(cpu.return_from_irq_instr & ~act_hi_q)) | (cpu.irq_ack & ~ack_hi); // RL6
            CPU_FLAGS   <= flags_v;
            IN_SERVICE  <= {act_hi_q, act_lo_q};
        end
    end
endmodule : icefl_dev

/* icefl_if.sv */
// Link between the interrupt logic and the CPU core
`timescale 1ns/10ps
interface icefl_if;
    icefl_pkg::icefl_byte_type sfr_addr;
    icefl_pkg::icefl_byte_type sfr_wdata;
    icefl_pkg::icefl_byte_type sfr_rdata;
    logic                      sfr_wr;
    logic                      sfr_rd;
    logic                      irq_req;
    icefl_pkg::icefl_src_type  irq_src;
    icefl_pkg::icefl_vec_type  irq_vec;
    logic                      irq_ack;
    icefl_pkg::icefl_src_type  irq_ack_src;
    logic                      return_from_irq_instr;

    modport dev (
        input  sfr_addr, sfr_wdata, sfr_wr, sfr_rd, irq_ack, irq_ack_src, return_from_irq_instr,
        output sfr_rdata, irq_req, irq_src, irq_vec
    );
    modport cpu (
        output sfr_addr, sfr_wdata, sfr_wr, sfr_rd, irq_ack, irq_ack_src, return_from_irq_instr,
        input  sfr_rdata, irq_req, irq_src, irq_vec
    );
endinterface : icefl_if

/* icefl_pkg.sv */
// Types shared by both ends of the interrupt logic
package icefl_pkg;
    typedef logic [3:0]  icefl_src_type;
    typedef logic [9:0]  icefl_srcvec_type;
    typedef logic [7:0]  icefl_byte_type;
    typedef logic [15:0] icefl_vec_type;
    typedef logic [2:0]  icefl_cnt_type;
    typedef enum logic [1:0]
    {
        ICEFL_IDLE = 2'b01,
        ICEFL_CALL = 2'b10
    } icefl_state_type;
endpackage : icefl_pkg

/* icefl_regs.svh */
// Register offsets, field positions, reset values and timing counts of the interrupt logic
`ifndef ICEFL_REGS_SVH
`define ICEFL_REGS_SVH

// Register offsets on the CPU register bus
`define ICEFL_FLAGS_FIRST_ADDR   8'h88
`define ICEFL_EN_THIRD_ADDR      8'h9a
`define ICEFL_EN_FIRST_ADDR      8'ha8
`define ICEFL_PRIO_ADDR          8'ha9
`define ICEFL_EN_SECOND_ADDR     8'hb8
`define ICEFL_FLAGS_AUX_ADDR     8'hd9

// Reset values
`define ICEFL_FLAGS_FIRST_RST    8'h05
`define ICEFL_EN_RST             8'h00
`define ICEFL_PRIO_RST           8'h00
`define ICEFL_AUX_RST            6'h00

// First enable register fields
`define ICEFL_GLOBAL_EN_BIT      7
`define ICEFL_SERIAL1_RX_EN_BIT  3
`define ICEFL_SERIAL0_RX_EN_BIT  2
`define ICEFL_CONVERTER_EN_BIT   1
`define ICEFL_RADIO_DONE_EN_BIT  0

// Second enable register fields
`define ICEFL_WATCHDOG_EN_BIT    5
`define ICEFL_PORT_ONE_EN_BIT    4
`define ICEFL_SERIAL1_TX_EN_BIT  3
`define ICEFL_SERIAL0_TX_EN_BIT  2
`define ICEFL_PORT_TWO_EN_BIT    1
`define ICEFL_RADIO_GEN_EN_BIT   0

// Sources: 0 radio done, 1 serial0 rx, 2 converter, 3 serial1/audio rx,
// 4 radio general, 5 port two/usb, 6 serial0 tx, 7 serial1/audio tx, 8 port one, 9 watchdog
`define ICEFL_NSRC               10
`define ICEFL_NHWCLR             4
`define ICEFL_NAUX               6
`define ICEFL_NGROUP             5

// Vector table layout
`define ICEFL_VEC_BASE           16'h0003
`define ICEFL_VEC_STEP           16'h0008

// Timing in clock cycles, one clock per instruction cycle
`define ICEFL_DETECT_CYC         1
`define ICEFL_CALL_CYC           6
`define ICEFL_LATENCY_CYC        (`ICEFL_DETECT_CYC + `ICEFL_CALL_CYC)

`endif
